// ### verilog/fcd_fir_front.sv
/*
  Dual FIR front end: coefficient store, control registers, forward and
  reverse decimation chains, LIFO feedback, pre-adder ALUs, input FIFO.
  Assumes all inputs synchronous to clk; multipliers sit downstream.
*/
// Operation
// R1 - Four banks of 32 coefficients per filter
// R2 - Set select picks coefficients every clock
// R3 - Store write data on write strobe rise
// R4 - Address splits bank, filter, set, coef flag
// R5 - Writes accepted any time, independent of flow
// R6 - Second control sets data/coef formats
// R7 - Bit four low enables data reversal
// R8 - Shift hold freezes input and decimation registers
// R9 - LIFOs swap on strobe falling edge
// R10 - Host sets block length by strobe period
// R11 - Host keeps strobe period and phase fixed
// R12 - Reversal off: feedback delay equals decimation
// R13 - Single mode cascades; filter B turns around
// R14 - Even taps take stage three, odd earlier
// R15 - Decimation delay programmable one to sixteen
// R16 - Host reads output once per N clocks
// R17 - Path selects gate ALU operands to zero
// R18 - Both selected: B plus or minus A
// R19 - Forward only: pass or negate A
// R20 - Reverse only: pass B
// R21 - Neither selected: ALU gives zero
// R22 - Rounding position and enable fields
// R23 - First control sets decimation factor
// R24 - First control selects dual or single
// R25 - Symmetry select steers ALU operation
`default_nettype none
module fcd_fifo #(
  parameter int W = 20,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                full;
    logic                empty;
    logic                ready;
  } fcd_fifo_st_t;
  fcd_fifo_st_t s_r, s_nxt;
  logic push, pop;

  always_comb
  begin
    s_nxt = s_r;
    push = in_valid && !s_r.full;
    pop = out_ready && !s_r.empty;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_nxt.full = s_nxt.cnt == (AW+1)'(D);
    s_nxt.empty = s_nxt.cnt == '0;
    s_nxt.ready = !s_nxt.full;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.empty <= 1'b1;
      s_r.ready <= 1'b1;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign in_ready = s_r.ready;
  assign out_valid = !s_r.empty;
  assign out_data = s_r.mem[s_r.rp];
endmodule

module fcd_fir_front #(
  parameter int FIFO_DEPTH = fcd_pkg::FIFO_D
) (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic                                 ce,
  input  wire logic [fcd_pkg::DW-1:0]               sample_in_a,
  input  wire logic [fcd_pkg::DW-1:0]               sample_in_b,
  input  wire logic                                 in_valid,
  output logic                                      in_ready,
  input  wire logic                                 shift_hold,
  input  wire logic                                 lifo_swap_strobe_n,
  input  wire logic                                 forward_select_n,
  input  wire logic                                 reverse_select_n,
  input  wire logic [4:0]                           coef_set_select,
  input  wire logic                                 wr_n,
  input  wire logic [8:0]                           coef_write_address,
  input  wire logic [9:0]                           coef_write_data,
  output logic [fcd_pkg::STG-1:0][fcd_pkg::DW-1:0]  coef_a,
  output logic [fcd_pkg::STG-1:0][fcd_pkg::DW-1:0]  coef_b,
  output fcd_pkg::fcd_alu_t                         alu,
  output fcd_pkg::fcd_ctrl_t                        ctrl
);
  typedef struct packed {
    logic [1:0][fcd_pkg::SETS-1:0][3:0][9:0]       coef;
    fcd_pkg::fcd_ctrl_t                            ctrl;
    logic [8:0]                                    waddr;
    logic                                          wr_prev;
    logic                                          swp_prev;
    logic [1:0][3:0][fcd_pkg::MAXD-1:0][9:0]       fwd;
    logic [1:0][3:0][fcd_pkg::MAXD-1:0][9:0]       rev;
    fcd_pkg::fcd_fb_t [1:0]                        fb;
    logic [1:0][3:0][9:0]                          cset;
    fcd_pkg::fcd_alu_t                             alu;
  } fcd_st_t;

  fcd_st_t s_r, s_nxt;
  fcd_pkg::fcd_samp_t fq;
  logic fq_valid, shift, swp_fall, wr_rise, dual, lifo_wr;
  logic [3:0] dec;
  logic [1:0] reven;
  logic [1:0][9:0] fin, rin, fbsrc, fbo;
  logic [1:0][3:0][9:0] fo, ro;
  logic [1:0][3:0][11:0] opa, opb;

  function automatic logic [9:0] tap(input logic [15:0][9:0] sr, input logic [3:0] d);
    return sr[d];
  endfunction

  function automatic logic [11:0] ext(input logic [9:0] v, input logic tc);
    return tc ? {{2{v[9]}}, v} : {2'b00, v};
  endfunction

  function automatic logic [11:0] alu_op(input logic [11:0] a, input logic [11:0] b,
                                         input logic fn, input logic rn, input logic odd);
    logic [11:0] ga, gb;
    ga = fn ? 12'h000 : a;
    gb = rn ? 12'h000 : b;
    if (!fn && !rn)
      return odd ? gb - ga : gb + ga;
    else if (!fn)
      return odd ? 12'h000 - ga : ga;
    else
      return gb;
  endfunction

  fcd_fifo #(.W($bits(fcd_pkg::fcd_samp_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({sample_in_b, sample_in_a}),
    .out_valid (fq_valid),
    .out_ready (!shift_hold),
    .out_data  (fq)
  );

  always_comb
  begin
    s_nxt = s_r;
    dec = s_r.ctrl.c0[fcd_pkg::C0_DEC +: 4];                         // [R23] [R15]
    dual = s_r.ctrl.c0[fcd_pkg::C0_DUAL];                             // [R24]
    shift = !shift_hold && fq_valid;                                  // [R8]
    swp_fall = s_r.swp_prev && !lifo_swap_strobe_n;                  // [R9]
    wr_rise = !s_r.wr_prev && wr_n;
    s_nxt.swp_prev = lifo_swap_strobe_n;
    s_nxt.wr_prev = wr_n;
    lifo_wr = 1'b0;
    for (int f = 0; f < 2; f++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        fo[f][k] = tap(s_r.fwd[f][k], dec);
        ro[f][k] = tap(s_r.rev[f][k], dec);
      end
      if (s_r.ctrl.c0[fcd_pkg::C0_EVA + f])
        fbsrc[f] = fo[f][2];                                          // [R14]
      else
        fbsrc[f] = (dec == 4'h0) ? fo[f][1] : s_r.fwd[f][2][dec - 4'h1]; // [R14]
      reven[f] = !s_r.ctrl.c1[fcd_pkg::C1_REVN] && (dual || f == 1);   // [R7] [R13]
      if (!reven[f])
        fbo[f] = tap(s_r.fb[f].fbd, dec);                             // [R12]
      else if (s_r.fb[f].rcnt != 5'h00)
        fbo[f] = s_r.fb[f].lifo[!s_r.fb[f].ws][s_r.fb[f].rcnt[3:0] - 4'h1];
      else
        fbo[f] = 10'h000;
    end
    fin[0] = fq.a;
    fin[1] = !dual ? fo[0][3] : (s_r.ctrl.c0[fcd_pkg::C0_BSRC] ? fq.b : fq.a); // [R13]
    rin[0] = dual ? fbo[0] : ro[1][3];                                // [R13]
    rin[1] = fbo[1];
    for (int f = 0; f < 2; f++)
    begin
      if (shift)
      begin
        for (int k = 0; k < 4; k++)
        begin
          s_nxt.fwd[f][k] = {s_r.fwd[f][k][14:0], (k == 0) ? fin[f] : fo[f][(k + 3) % 4]}; // [R8]
          s_nxt.rev[f][k] = {s_r.rev[f][k][14:0], (k == 0) ? rin[f] : ro[f][(k + 3) % 4]};
        end
        s_nxt.fb[f].fbd = {s_r.fb[f].fbd[14:0], fbsrc[f]};
        if (reven[f] && s_r.fb[f].wcnt != 5'h10)
        begin
          s_nxt.fb[f].lifo[s_r.fb[f].ws][s_r.fb[f].wcnt[3:0]] = fbsrc[f]; // [R9]
          s_nxt.fb[f].wcnt = s_r.fb[f].wcnt + 5'h01;
          lifo_wr = 1'b1;
        end
        if (s_r.fb[f].rcnt != 5'h00)
          s_nxt.fb[f].rcnt = s_r.fb[f].rcnt - 5'h01;
      end
      if (swp_fall && reven[f])
      begin
        s_nxt.fb[f].ws = !s_r.fb[f].ws;                                 // [R9]
        s_nxt.fb[f].rcnt = s_nxt.fb[f].wcnt;
        s_nxt.fb[f].wcnt = 5'h00;
      end
      for (int k = 0; k < 4; k++)
      begin
        opa[f][k] = ext(fo[f][k], s_r.ctrl.c1[fcd_pkg::C1_FMTDA + 2*f]);      // [R6]
        opb[f][k] = ext(ro[f][3-k], s_r.ctrl.c1[fcd_pkg::C1_FMTDA + 2*f]);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      s_nxt.alu.a[k] = alu_op(opa[0][k], opb[0][k], forward_select_n, reverse_select_n,
                              s_r.ctrl.c0[fcd_pkg::C0_ODD]);          // [R17] [R25]
      s_nxt.alu.b[k] = alu_op(opa[1][k], opb[1][k], forward_select_n, reverse_select_n,
                              s_r.ctrl.c0[fcd_pkg::C0_ODD]);          // [R18] [R19] [R20] [R21]
    end
    for (int f = 0; f < 2; f++)
      s_nxt.cset[f] = s_r.coef[f][coef_set_select];                   // [R1] [R2]
    if (s_r.wr_prev && !wr_n)
      s_nxt.waddr = coef_write_address;
    if (wr_rise)
    begin
      if (s_r.waddr[fcd_pkg::A_COEF])                                 // [R4] [R5]
        s_nxt.coef[s_r.waddr[fcd_pkg::A_FILT]][s_r.waddr[7:3]][s_r.waddr[1:0]] = coef_write_data; // [R3]
      else if (s_r.waddr == fcd_pkg::ADDR_CTRL0)
        s_nxt.ctrl.c0 = coef_write_data;
      else if (s_r.waddr == fcd_pkg::ADDR_CTRL1)
        s_nxt.ctrl.c1 = coef_write_data;                              // [R6] [R22]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.wr_prev <= 1'b1;
      s_r.ctrl.c0 <= fcd_pkg::CTRL0_RST;
      s_r.ctrl.c1 <= fcd_pkg::CTRL1_RST;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign coef_a = s_r.cset[0];
  assign coef_b = s_r.cset[1];
  assign alu = s_r.alu;
  assign ctrl = s_r.ctrl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ctrl1_write_a: assert property (ce && wr_rise && s_r.waddr == fcd_pkg::ADDR_CTRL1 // [R3]
    |=> ctrl.c1 == $past(coef_write_data)) else $error("control write lost");
  hold_freeze_a: assert property (ce && shift_hold |=> $stable(s_r.fwd) && $stable(s_r.rev)) // [R8]
    else $error("chain moved under hold");
  lifo_swap_a: assert property (ce && swp_fall && reven[1] |=> s_r.fb[1].ws != $past(s_r.fb[1].ws)) // [R9]
    else $error("no swap on strobe fall");
  no_swap_a: assert property (ce && !swp_fall |=> $stable(s_r.fb[1].ws)) // [R9]
    else $error("swap without strobe fall");
  alu_sum_a: assert property (ce && !forward_select_n && !reverse_select_n && !ctrl.c0[5] // [R18]
    |=> alu.a[0] == 12'($past(opb[0][0]) + $past(opa[0][0]))) else $error("sum wrong");
  alu_diff_a: assert property (ce && !forward_select_n && !reverse_select_n && ctrl.c0[5] // [R18]
    |=> alu.b[1] == 12'($past(opb[1][1]) - $past(opa[1][1]))) else $error("difference wrong");
  alu_nega_a: assert property (ce && !forward_select_n && reverse_select_n && ctrl.c0[5] // [R19]
    |=> alu.a[2] == 12'(12'h000 - $past(opa[0][2]))) else $error("negate wrong");
  alu_passb_a: assert property (ce && forward_select_n && !reverse_select_n // [R20]
    |=> alu.b[3] == $past(opb[1][3])) else $error("pass B wrong");
  alu_zero_a: assert property (ce && forward_select_n && reverse_select_n // [R21]
    |=> alu == '0) else $error("ALU not zero");
  coef_sel_a: assert property (ce ##1 ce |=> coef_a == $past(s_r.coef[0][coef_set_select])) // [R2]
    else $error("coefficient set mismatch");

  swap_seen_c: cover property (ce && swp_fall && reven[0]);
  coef_wr_c: cover property (ce && wr_rise && s_r.waddr[8]);
  fifo_full_c: cover property (!in_ready);
  single_mode_c: cover property (ce && shift && !dual);
  lifo_fill_c: cover property (ce && lifo_wr);
endmodule
`default_nettype wire

// ### verilog/fcd_pkg.sv
/*
  Shared constants and carrier types for the dual FIR front end:
  register addresses, control field positions, reset values, sizes.
  Assumes one synchronous clock domain and a host on the write port.
*/
`default_nettype none
package fcd_pkg;
  localparam int DW     = 10;
  localparam int AUW    = 12;
  localparam int SETS   = 32;
  localparam int STG    = 4;
  localparam int MAXD   = 16;
  localparam int FIFO_D = 32;

  localparam logic [8:0] ADDR_CTRL0 = 9'h000;
  localparam logic [8:0] ADDR_CTRL1 = 9'h001;
  localparam int A_COEF   = 8;
  localparam int A_FILT   = 2;

  localparam int C0_DEC   = 0;
  localparam int C0_DUAL  = 4;
  localparam int C0_ODD   = 5;
  localparam int C0_EVA   = 6;
  localparam int C0_EVB   = 7;
  localparam int C0_BSRC  = 8;
  localparam int C1_FMTDA = 0;
  localparam int C1_FMTDB = 2;
  localparam int C1_REVN  = 4;
  localparam int C1_RPOS  = 5;
  localparam int C1_RNDN  = 9;

  localparam logic [9:0] CTRL0_RST = 10'h010;
  localparam logic [9:0] CTRL1_RST = 10'h210;

  typedef struct packed {
    logic [DW-1:0] b;
    logic [DW-1:0] a;
  } fcd_samp_t;

  typedef struct packed {
    logic [9:0] c1;
    logic [9:0] c0;
  } fcd_ctrl_t;

  typedef struct packed {
    logic [STG-1:0][AUW-1:0] b;
    logic [STG-1:0][AUW-1:0] a;
  } fcd_alu_t;

  typedef struct packed {
    logic [1:0][MAXD-1:0][DW-1:0] lifo;
    logic                         ws;
    logic [4:0]                   wcnt;
    logic [4:0]                   rcnt;
    logic [MAXD-1:0][DW-1:0]      fbd;
  } fcd_fb_t;
endpackage
`default_nettype wire

// ### verification/fcd_host_model.sv
/*
  Host sample source: offers one pair at a time on valid/ready and keeps
  the swap strobe. Assumes the bench sets the pair and the enable.
*/
`default_nettype none
module fcd_host_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       en,
  input  wire logic       swap_on,
  input  wire logic [9:0] val_a,
  input  wire logic [9:0] val_b,
  input  wire logic       in_ready,
  output logic [9:0]      sample_in_a,
  output logic [9:0]      sample_in_b,
  output logic            in_valid,
  output logic            lifo_swap_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       took;
  logic [2:0] phase = 3'h0;
  initial
  begin
    sample_in_a        = 10'h000;
    sample_in_b        = 10'h000;
    in_valid           = 1'b0;
    lifo_swap_strobe_n = 1'b0;
  end
  always @(posedge clk or negedge rstn)
    if (!rstn)
      took <= 1'b0;
    else
      took <= in_valid & in_ready & ce;
  // Pair is held until taken; idle lines toggle so no stale value shows
  always @(negedge clk)
  begin
    phase <= phase + 3'h1;
    // Strobe low one cycle in eight while reversal runs, else held low
    lifo_swap_strobe_n <= swap_on && phase != 3'h7;
    if (!en || !rstn)
    begin
      in_valid    <= 1'b0;
      sample_in_a <= ~sample_in_a;
      sample_in_b <= ~sample_in_b;
    end
    else if (!in_valid || took)
    begin
      in_valid    <= 1'b1;
      sample_in_a <= val_a;
      sample_in_b <= val_b;
    end
  end
endmodule
`default_nettype wire

// ### verification/fcd_testbench.sv
/*
  Self-checking bench for the FIR front end: reset values, writes, buffer
  fill, shift hold and ALU operations. Assumes the host model beside it.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    int          kind;
    logic [95:0] v;
    string       name;
  } fcd_note_t;
  logic                                           clk = 1'b0;
  logic                                           rstn = 1'b0;
  logic                                           ce = 1'b1;
  logic                                           en = 1'b0;
  logic                                           swap_on = 1'b0;
  logic [9:0]                                     val_a = 10'h000;
  logic [9:0]                                     val_b = 10'h000;
  logic [9:0]                                     sample_in_a;
  logic [9:0]                                     sample_in_b;
  logic                                           in_valid;
  logic                                           in_ready;
  logic                                           lifo_swap_strobe_n;
  logic                                           shift_hold = 1'b0;
  logic                                           forward_select_n = 1'b0;
  logic                                           reverse_select_n = 1'b0;
  logic [4:0]                                     coef_set_select = 5'h00;
  logic                                           wr_n = 1'b1;
  logic [8:0]                                     coef_write_address = 9'h000;
  logic [9:0]                                     coef_write_data = 10'h000;
  logic [fcd_pkg::STG-1:0][fcd_pkg::DW-1:0]       coef_a;
  logic [fcd_pkg::STG-1:0][fcd_pkg::DW-1:0]       coef_b;
  fcd_pkg::fcd_alu_t                              alu;
  fcd_pkg::fcd_ctrl_t                             ctrl;
  int                                             fail_count = 0;
  int                                             samples_checked = 0;
  int                                             seed = 32'h55a8;
  fcd_note_t                                      notes[$];

  always #4 clk = ~clk;

  fcd_host_model u_host (.clk(clk), .rstn(rstn), .ce(ce), .en(en), .swap_on(swap_on), .val_a(val_a),
    .val_b(val_b), .in_ready(in_ready), .sample_in_a(sample_in_a), .sample_in_b(sample_in_b), .in_valid(in_valid),
    .lifo_swap_strobe_n(lifo_swap_strobe_n));

  fcd_fir_front u_dut (.clk(clk), .rstn(rstn), .ce(ce), .sample_in_a(sample_in_a), .sample_in_b(sample_in_b),
    .in_valid(in_valid), .in_ready(in_ready), .shift_hold(shift_hold), .lifo_swap_strobe_n(lifo_swap_strobe_n),
    .forward_select_n(forward_select_n), .reverse_select_n(reverse_select_n), .coef_set_select(coef_set_select),
    .wr_n(wr_n), .coef_write_address(coef_write_address), .coef_write_data(coef_write_data),
    .coef_a(coef_a), .coef_b(coef_b), .alu(alu), .ctrl(ctrl));

  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Expectation is queued after an edge and compared at the next falling edge
  task automatic note(input int k, input logic [95:0] v, input string s);
    @(posedge clk);
    #1;
    notes.push_back('{k, v, s});
    @(negedge clk);
  endtask

  always @(negedge clk)
    while (notes.size() > 0)
    begin
      fcd_note_t n;
      n = notes.pop_front();
      case (n.kind)
        0: check(n.name, alu, n.v);
        1: check(n.name, {76'h0, ctrl}, n.v);
        2: check(n.name, {16'h0, coef_b, coef_a}, n.v);
        default: check(n.name, {95'h0, in_ready}, n.v);
      endcase
    end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [8:0] a, input logic [9:0] d);
    wr_n               = 1'b0;
    coef_write_address = a;
    @(negedge clk);
    wr_n            = 1'b1;
    coef_write_data = d;
    @(negedge clk);
  endtask

  // m is {odd symmetry, forward_select_n, reverse_select_n}
  function automatic logic [11:0] op(input logic [9:0] x, input logic s, input logic [2:0] m);
    logic [11:0] e;
    logic [11:0] a;
    e = s ? {{2{x[9]}}, x} : {2'h0, x};
    a = m[1] ? 12'h000 : e;
    return (m[0] ? 12'h000 : e) + (m[2] ? -a : a);
  endfunction

  function automatic logic [95:0] alu_exp(input logic [9:0] va, input logic [9:0] vb, input logic [2:0] m,
                                          input logic f);
    return {{4{op(vb, f, m)}}, {4{op(va, f, m)}}};
  endfunction

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    int          s;
    int          k;
    int          m;
    int          j;
    int          i;
    logic [4:0]  set;
    logic [9:0]  c [8];
    logic [9:0]  c0;
    logic [9:0]  c1;
    logic [95:0] e_hold;
    cyc(8);
    rstn = 1'b1;
    note(1, {76'h0, fcd_pkg::CTRL1_RST, fcd_pkg::CTRL0_RST}, "ctrl reset");
    note(3, 96'h1, "in_ready reset");
    note(2, 96'h0, "coef reset");
    for (s = 0; s < 2; s++)
    begin
      set = 5'($random(seed));
      for (k = 0; k < 8; k++)
      begin
        c[k] = 10'($random(seed));
        wr({1'b1, set, k[2:0]}, c[k]);
      end
      coef_set_select = set;
      wr({1'b0, set, 3'h3}, ~c[3]);
      cyc(2);
      note(2, {16'h0, c[7], c[6], c[5], c[4], c[3], c[2], c[1], c[0]}, "coef set");
    end
    en = 1'b1;
    for (m = 0; m < 4; m++)
    begin
      c0 = {2'h1, m != 1, m != 1, m[1], m != 2, 4'h3};
      c1 = {3'h4, m[1:0], m[0], 1'b0, m[0], 1'b0, m[0]};
      swap_on = !c1[fcd_pkg::C1_REVN];
      wr(fcd_pkg::ADDR_CTRL0, c0);
      wr(fcd_pkg::ADDR_CTRL1, c1);
      note(1, {76'h0, c1, c0}, "ctrl");
      val_a = 10'($random(seed));
      val_b = 10'($random(seed));
      cyc(120);
      for (j = 0; j < 4; j++)
      begin
        {forward_select_n, reverse_select_n} = j[1:0];
        cyc(2);
        note(0, alu_exp(val_a, (m == 2) ? val_a : val_b, {m[1], j[1:0]}, m[0]), "alu op");
      end
    end
    {forward_select_n, reverse_select_n} = 2'b01;
    cyc(2);
    shift_hold = 1'b1;
    e_hold = alu_exp(val_a, val_b, 3'b101, 1'b1);
    val_a = 10'($random(seed));
    val_b = 10'($random(seed));
    for (i = 0; i < 100 && in_ready !== 1'b0; i++)
      @(negedge clk);
    if (i == 100)
      fail_count++;
    note(3, 96'h0, "in_ready full");
    note(0, e_hold, "alu held");
    shift_hold = 1'b0;
    cyc(100);
    note(0, alu_exp(val_a, val_b, 3'b101, 1'b1), "alu after hold");
    ce = 1'b0;
    {forward_select_n, reverse_select_n} = 2'b11;
    cyc(2);
    note(0, alu_exp(val_a, val_b, 3'b101, 1'b1), "alu frozen");
    ce = 1'b1;
    cyc(2);
    note(0, 96'h0, "alu zero");
    en = 1'b0;
    cyc(40);
    note(3, 96'h1, "in_ready drained");
    finish_test();
  end
endmodule
`default_nettype wire
